// file: core/ddr_pkg.sv
// Shared constants and types for the burst-timing link ends
package ddr_pkg;
   // ------------------------------------------------------------
   // Link geometry
   // ------------------------------------------------------------
   localparam int BANK_W = 3; // Bank select width
   localparam int ADDR_W = 13; // Command address width
   localparam int COL_W = 10; // Column field width
   localparam int ROW_W = 13; // Row field width
   localparam int BSEL_POS = 12; // Burst-select address bit position
   localparam int AP_POS = 10; // Auto-precharge flag position
   localparam int BEAT_W = 16; // One data beat
   localparam int WORD_W = 32; // Two beats per clock
   localparam int MEM_AW = 9; // Storage index: bank plus six column bits
   localparam int MEM_DEPTH = 512; // Stored beats
   localparam int FIFO_DEPTH = 32; // Write data buffer words

   // ------------------------------------------------------------
   // Commands and burst-length field encodings
   // ------------------------------------------------------------
   typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE} cmd_e;
   localparam logic [1:0] BLMODE_FIXED8 = 2'h0; // Fixed full eight-beat burst
   localparam logic [1:0] BLMODE_OTF = 2'h1; // Per-command selection
   localparam logic [1:0] BLMODE_FIXED4 = 2'h2; // Fixed chopped four-beat burst

   // ------------------------------------------------------------
   // Latencies and timing, 125 MHz clock
   // ------------------------------------------------------------
   localparam int CLK_PS = 8000; // Clock period in ps
   localparam int ADDITIVE_LATENCY = 0; // Additive latency in clocks
   localparam int CAS_LAT = 6; // Read CAS latency
   localparam int CAS_WR_LAT = 5; // Write CAS latency
   localparam int RD_LAT = ADDITIVE_LATENCY + CAS_LAT; // Read latency
   localparam int WR_LAT = ADDITIVE_LATENCY + CAS_WR_LAT; // Write latency
   localparam int CLK_EIGHT = 4; // Clocks of an eight-beat burst
   localparam int CLK_FOUR = 2; // Clocks of a chopped burst
   localparam int CCD_CYC = 4; // Column-to-column spacing
   localparam int RTP_MIN_CYC = 4; // Read-to-precharge floor in clocks
   localparam int RTP_PS = 7500; // Read-to-precharge floor in ps
   localparam int RTP_CYC = (RTP_MIN_CYC > (RTP_PS + CLK_PS - 1) / CLK_PS) ?
                            RTP_MIN_CYC : (RTP_PS + CLK_PS - 1) / CLK_PS;
   localparam int RP_PS = 15000; // Precharge period
   localparam int RAS_PS = 37500; // Activate-to-precharge
   localparam int RC_PS = 52500; // Activate-to-activate
   localparam int RCD_PS = 15000; // Activate-to-column
   localparam int WR_REC_PS = 15000; // Write recovery
   localparam int RP_CYC = (RP_PS + CLK_PS - 1) / CLK_PS;
   localparam int RAS_CYC = (RAS_PS + CLK_PS - 1) / CLK_PS;
   localparam int RC_CYC = (RC_PS + CLK_PS - 1) / CLK_PS;
   localparam int RCD_CYC = (RCD_PS + CLK_PS - 1) / CLK_PS;
   localparam int WR_REC_CYC = (WR_REC_PS + CLK_PS - 1) / CLK_PS;
   localparam int INIT_CYC = 16; // Quiet clocks of the init sequence
   localparam logic [7:0] TIMER_MAX = 8'hff; // Saturated per-bank timer
endpackage

// file: core/ddr_link_if.sv
// Command and strobed data link between controller and memory
`timescale 1ns/1ps
interface ddr_link_if;
   ddr_pkg::cmd_e cmd; // Command this clock
   logic [ddr_pkg::BANK_W-1:0] bank; // Bank select
   logic [ddr_pkg::ADDR_W-1:0] addr; // Row or column plus flags
   logic [ddr_pkg::WORD_W-1:0] ctl_dq_o; // Controller data drive
   logic ctl_dq_oe; // Controller drives data
   logic ctl_dqs_o; // Controller strobe drive
   logic ctl_dqs_oe; // Controller drives strobe
   logic [ddr_pkg::WORD_W-1:0] dev_dq_o; // Device data drive
   logic dev_dq_oe; // Device drives data
   logic dev_dqs_o; // Device strobe drive
   logic dev_dqs_oe; // Device drives strobe
   logic [ddr_pkg::WORD_W-1:0] dq; // Resolved data wire
   logic dqs; // Resolved strobe wire

   // Wire resolution, undriven reads as zero
   assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
   assign dqs = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : 1'b0);

   modport ctl (output cmd, bank, addr, ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe, input dq, dqs);
   modport dev (input cmd, bank, addr, dq, dqs, output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe);
endinterface

// file: core/sync_fifo.sv
// Single-clock FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic mclk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word in
   output logic out_valid, // Word available
   input wire logic out_ready, // Consumer takes word
   output logic [WIDTH-1:0] out_data // Oldest word
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH]; // Word storage
   logic [PW-1:0] wr_ptr; // Write index
   logic [PW-1:0] rd_ptr; // Read index
   logic [PW:0] count; // Words held
   logic push; // Word enters
   logic pop; // Word leaves
   logic [PW:0] next_count; // Occupancy after this clock

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = store[rd_ptr];
   assign next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

   // Storage writes
   always_ff @(posedge mclk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   // Pointers, occupancy and honest flags
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
         rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
         count <= next_count;
         in_ready <= (next_count != (PW+1)'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end
endmodule

// file: core/dram_end.sv
// Memory end: burst-length decode, latency pipes, burst engines, storage
`timescale 1ns/1ps
module dram_end (
   input wire logic mclk, // Link clock
   input wire logic rst_n, // Async reset, active low
   ddr_link_if.dev link, // Link to controller
   input wire logic [1:0] burst_len_mode, // Burst-length field of first_mode_register
   output logic write_fault, // Pulse: write beat arrived without strobe
   output logic last_burst_eight // Last column command was eight beats
);
   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   logic is_col; // Read or write this clock
   logic eight; // Burst length chosen for it
   logic [5:0] col_low; // Column bits used for storage
   assign is_col = (link.cmd == ddr_pkg::CMD_RD) || (link.cmd == ddr_pkg::CMD_WR);
   // Fixed, per-command, or fixed-chop selection
   assign eight = (burst_len_mode == ddr_pkg::BLMODE_FIXED8) || // R4
                  ((burst_len_mode == ddr_pkg::BLMODE_OTF) && link.addr[ddr_pkg::BSEL_POS]); // R1 R5
   // Column taken from low bits only; select bit stays out
   assign col_low = link.addr[5:0]; // R2

   // ------------------------------------------------------------
   // Latency pipes, one stage per clock
   // ------------------------------------------------------------
   localparam int RP = ddr_pkg::RD_LAT - 1;
   localparam int WP = ddr_pkg::WR_LAT;
   logic rd_v [RP]; // Read pending
   logic wr_v [WP]; // Write pending
   logic [ddr_pkg::MEM_AW-1:0] rd_a [RP]; // Read start index
   logic [ddr_pkg::MEM_AW-1:0] wr_a [WP]; // Write start index
   logic rd_e [RP]; // Read is eight beats
   logic wr_e [WP]; // Write is eight beats

   // Shift pipes; auto-precharge flag does not change acceptance
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < RP; i++) begin
            rd_v[i] <= 1'b0;
            rd_a[i] <= '0;
            rd_e[i] <= 1'b0;
         end
         for (int i = 0; i < WP; i++) begin
            wr_v[i] <= 1'b0;
            wr_a[i] <= '0;
            wr_e[i] <= 1'b0;
         end
      end else begin
         rd_v[0] <= link.cmd == ddr_pkg::CMD_RD; // R3
         rd_a[0] <= {link.bank, col_low};
         rd_e[0] <= eight;
         wr_v[0] <= link.cmd == ddr_pkg::CMD_WR; // R3
         wr_a[0] <= {link.bank, col_low};
         wr_e[0] <= eight;
         for (int i = 1; i < RP; i++) begin
            rd_v[i] <= rd_v[i-1];
            rd_a[i] <= rd_a[i-1];
            rd_e[i] <= rd_e[i-1];
         end
         for (int i = 1; i < WP; i++) begin
            wr_v[i] <= wr_v[i-1];
            wr_a[i] <= wr_a[i-1];
            wr_e[i] <= wr_e[i-1];
         end
      end
   end

   // Remember the burst length chosen last
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         last_burst_eight <= 1'b0;
      end else if (is_col) begin
         last_burst_eight <= eight;
      end
   end

   // ------------------------------------------------------------
   // Storage and burst engines
   // ------------------------------------------------------------
   logic [ddr_pkg::BEAT_W-1:0] mem [ddr_pkg::MEM_DEPTH]; // Beat storage
   logic [ddr_pkg::MEM_AW-1:0] rd_idx; // Next read pair start
   logic [ddr_pkg::MEM_AW-1:0] wr_idx; // Next write pair start
   logic [1:0] rd_left; // Read clocks still to send
   logic [1:0] wr_left; // Write clocks still to take
   logic [ddr_pkg::MEM_AW-1:0] rd_cur; // Read pair start this clock
   logic [ddr_pkg::MEM_AW-1:0] wr_cur; // Write pair start this clock
   logic rd_go; // Send a pair this clock
   logic wr_go; // Take a pair this clock

   // Beat index with in-burst wrap of the low three bits
   function automatic logic [ddr_pkg::MEM_AW-1:0] step(input logic [ddr_pkg::MEM_AW-1:0] a, input logic [2:0] n);
      step = {a[ddr_pkg::MEM_AW-1:3], 3'(a[2:0] + n)};
   endfunction

   assign rd_go = rd_v[RP-1] || (rd_left != 2'h0);
   assign rd_cur = rd_v[RP-1] ? rd_a[RP-1] : rd_idx;
   assign wr_go = wr_v[WP-1] || (wr_left != 2'h0);
   assign wr_cur = wr_v[WP-1] ? wr_a[WP-1] : wr_idx;

   // Read engine: one pair a clock, ends by count alone
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_left <= 2'h0;
         rd_idx <= '0;
         link.dev_dq_o <= '0;
         link.dev_dq_oe <= 1'b0;
         link.dev_dqs_o <= 1'b0;
         link.dev_dqs_oe <= 1'b0;
      end else begin
         if (rd_v[RP-1]) begin
            rd_left <= rd_e[RP-1] ? 2'(ddr_pkg::CLK_EIGHT - 1) : 2'(ddr_pkg::CLK_FOUR - 1);
         end else if (rd_left != 2'h0) begin
            rd_left <= rd_left - 2'h1;
         end
         rd_idx <= step(rd_cur, 3'h2);
         link.dev_dq_o <= rd_go ? {mem[step(rd_cur, 3'h1)], mem[rd_cur]} : '0;
         link.dev_dq_oe <= rd_go;
         link.dev_dqs_o <= rd_go;
         link.dev_dqs_oe <= rd_go;
      end
   end

   // Write engine: fixed length, a missing strobe never stalls it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_left <= 2'h0;
         wr_idx <= '0;
         write_fault <= 1'b0;
      end else begin
         if (wr_v[WP-1]) begin
            wr_left <= wr_e[WP-1] ? 2'(ddr_pkg::CLK_EIGHT - 1) : 2'(ddr_pkg::CLK_FOUR - 1);
         end else if (wr_left != 2'h0) begin
            wr_left <= wr_left - 2'h1;
         end
         wr_idx <= step(wr_cur, 3'h2);
         write_fault <= wr_go && !link.dqs; // R10 R11
      end
   end

   // Storage: a bad strobe only spoils this burst's own location
   always_ff @(posedge mclk) begin
      if (wr_go) begin
         mem[wr_cur] <= link.dq[ddr_pkg::BEAT_W-1:0]; // R10 R11
         mem[step(wr_cur, 3'h1)] <= link.dq[ddr_pkg::WORD_W-1:ddr_pkg::BEAT_W];
      end
   end
endmodule

// file: core/mem_ctl_end.sv
// Controller end: per-bank timers, command scheduling, strobed data
// Notes on behaviour
// R1 - Low select bit: chopped burst, spacing four
// R2 - High select bit: eight beats, not column
// R3 - Either length on reads, writes, any precharge
// R4 - Eight beats: field 00, or 01 with bit
// R5 - Field 10 always gives chopped bursts
// R6 - Precharge waits additive latency plus read-precharge
// R7 - Precharge also waits activate-to-precharge time
// R8 - Read-precharge delay is max of 4, 7.5ns
// R9 - Reactivate after precharge period and cycle time
// R10 - Bad data timing spoils only that write
// R11 - Bad strobe timing spoils only that write
// R12 - After violations, rerun reset and initialisation; code only reruns the init wait, on reinit in idle
// R13 - Every strobe edge of burst meets timing
// R14 - Keep per-bank activate, read, precharge timers
`timescale 1ns/1ps
module mem_ctl_end (
   input wire logic mclk, // System clock
   input wire logic rst_n, // Async reset, active low
   ddr_link_if.ctl link, // Link to memory
   input wire logic [1:0] burst_len_mode, // Burst-length field in use
   input wire logic reinit, // Pulse: rerun init sequence
   input wire logic req_valid, // Request offered
   output logic req_ready, // Request taken when valid
   input wire logic req_write, // Write when high
   input wire logic [ddr_pkg::BANK_W-1:0] req_bank, // Bank
   input wire logic [ddr_pkg::ROW_W-1:0] req_row, // Row
   input wire logic [ddr_pkg::COL_W-1:0] req_col, // Column
   input wire logic req_eight, // Ask for eight beats
   input wire logic wr_valid, // Write word offered
   output logic wr_ready, // Buffer has room
   input wire logic [ddr_pkg::WORD_W-1:0] wr_data, // Write word, two beats
   output logic rd_valid, // Pulse: read word
   output logic [ddr_pkg::WORD_W-1:0] rd_data, // Read word, two beats
   output logic init_done // Init sequence complete
);
   // ------------------------------------------------------------
   // Write data buffer
   // ------------------------------------------------------------
   logic fifo_valid; // Write word ready to send
   logic fifo_pop; // Take one word
   logic [ddr_pkg::WORD_W-1:0] fifo_data; // Word to send

   sync_fifo #(.WIDTH(ddr_pkg::WORD_W), .DEPTH(ddr_pkg::FIFO_DEPTH)) u_sync_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // ------------------------------------------------------------
   // Scheduler state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {S_INIT, S_IDLE, S_ACT, S_RCD, S_COL, S_DATA, S_PRE} state_e;
   state_e state; // Scheduler state
   logic op_write; // Latched direction
   logic op_eight; // Latched burst length
   logic [ddr_pkg::BANK_W-1:0] op_bank; // Latched bank
   logic [ddr_pkg::ROW_W-1:0] op_row; // Latched row
   logic [ddr_pkg::COL_W-1:0] op_col; // Latched column
   logic [7:0] wait_cnt; // General wait counter
   logic [7:0] since_col; // Clocks since last column command
   logic [7:0] since_act [8]; // Per-bank clocks since activate
   logic [7:0] since_pre [8]; // Per-bank clocks since precharge
   logic [7:0] since_rd [8]; // Per-bank clocks since read
   logic eight_eff; // Length the memory will use
   logic [7:0] burst_clk; // Data clocks of this burst
   logic act_ok; // Bank may be activated
   logic pre_ok; // Bank may be precharged
   logic col_ok; // Column spacing met
   logic [7:0] data_end; // Wait until burst and recovery done
   logic send_beat; // Drive a write word this clock

   // Same selection the memory makes
   assign eight_eff = (burst_len_mode == ddr_pkg::BLMODE_FIXED8) || // R4
                      ((burst_len_mode == ddr_pkg::BLMODE_OTF) && op_eight); // R5
   assign burst_clk = eight_eff ? 8'(ddr_pkg::CLK_EIGHT) : 8'(ddr_pkg::CLK_FOUR);
   // Reactivate: precharge period and activate cycle both met
   assign act_ok = (since_pre[op_bank] >= 8'(ddr_pkg::RP_CYC)) && // R9
                   (since_act[op_bank] >= 8'(ddr_pkg::RC_CYC)); // R9
   // Precharge: read spacing plus activate-to-precharge
   assign pre_ok = (since_rd[op_bank] >= 8'(ddr_pkg::ADDITIVE_LATENCY + ddr_pkg::RTP_CYC)) && // R6 R8
                   (since_act[op_bank] >= 8'(ddr_pkg::RAS_CYC)); // R7
   assign col_ok = since_col >= 8'(ddr_pkg::CCD_CYC); // R1
   assign data_end = op_write ? 8'(ddr_pkg::WR_LAT + ddr_pkg::WR_REC_CYC) + burst_clk
                              : 8'(ddr_pkg::RD_LAT) + burst_clk;
   assign send_beat = (state == S_DATA) && op_write &&
                      (wait_cnt >= 8'(ddr_pkg::WR_LAT - 1)) &&
                      (wait_cnt < 8'(ddr_pkg::WR_LAT - 1) + burst_clk);
   assign fifo_pop = send_beat && fifo_valid;

   // Column and per-bank timers, saturating; start ready for the first access
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         since_col <= ddr_pkg::TIMER_MAX;
         for (int b = 0; b < 8; b++) begin
            since_act[b] <= ddr_pkg::TIMER_MAX;
            since_pre[b] <= ddr_pkg::TIMER_MAX;
            since_rd[b] <= ddr_pkg::TIMER_MAX;
         end
      end else begin
         since_col <= (state == S_COL && col_ok) ? 8'h00 :
                      (since_col == ddr_pkg::TIMER_MAX ? since_col : since_col + 8'h01);
         for (int b = 0; b < 8; b++) begin
            if (since_act[b] != ddr_pkg::TIMER_MAX) since_act[b] <= since_act[b] + 8'h01; // R14
            if (since_pre[b] != ddr_pkg::TIMER_MAX) since_pre[b] <= since_pre[b] + 8'h01; // R14
            if (since_rd[b] != ddr_pkg::TIMER_MAX) since_rd[b] <= since_rd[b] + 8'h01; // R14
         end
         if (state == S_ACT && act_ok) since_act[op_bank] <= 8'h00; // R14
         if (state == S_PRE && pre_ok) since_pre[op_bank] <= 8'h00; // R14
         if (state == S_COL && col_ok && !op_write) since_rd[op_bank] <= 8'h00; // R14
      end
   end

   // Scheduler: closed page, one request at a time
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_INIT;
         wait_cnt <= 8'h00;
         req_ready <= 1'b0;
         init_done <= 1'b0;
         op_write <= 1'b0;
         op_eight <= 1'b0;
         op_bank <= '0;
         op_row <= '0;
         op_col <= '0;
         link.cmd <= ddr_pkg::CMD_NOP;
         link.bank <= '0;
         link.addr <= '0;
      end else begin
         link.cmd <= ddr_pkg::CMD_NOP;
         wait_cnt <= wait_cnt + 8'h01;
         case (state)
            S_INIT: begin
               // Quiet clocks before any command
               req_ready <= 1'b0;
               if (wait_cnt >= 8'(ddr_pkg::INIT_CYC - 1)) begin
                  state <= S_IDLE;
                  init_done <= 1'b1;
                  req_ready <= 1'b1;
               end
            end
            S_IDLE: begin
               if (reinit) begin
                  // Rerun the init sequence after a timing violation; timers and write buffer keep their state
                  state <= S_INIT; // R12
                  init_done <= 1'b0;
                  req_ready <= 1'b0;
                  wait_cnt <= 8'h00;
               end else if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  op_write <= req_write;
                  op_eight <= req_eight;
                  op_bank <= req_bank;
                  op_row <= req_row;
                  op_col <= req_col;
                  state <= S_ACT;
               end
            end
            S_ACT: begin
               // Activate once the bank timers allow it
               if (act_ok) begin
                  link.cmd <= ddr_pkg::CMD_ACT; // R9
                  link.bank <= op_bank;
                  link.addr <= op_row;
                  wait_cnt <= 8'h00;
                  state <= S_RCD;
               end
            end
            S_RCD: begin
               if (wait_cnt >= 8'(ddr_pkg::RCD_CYC - 1)) begin
                  state <= S_COL;
               end
            end
            S_COL: begin
               // Column command, select bit in its own place
               if (col_ok) begin
                  link.cmd <= op_write ? ddr_pkg::CMD_WR : ddr_pkg::CMD_RD;
                  link.bank <= op_bank;
                  link.addr <= '0;
                  link.addr[ddr_pkg::COL_W-1:0] <= op_col;
                  link.addr[ddr_pkg::AP_POS] <= 1'b0;
                  link.addr[ddr_pkg::BSEL_POS] <= op_eight; // R1 R2 R3
                  wait_cnt <= 8'h00;
                  state <= S_DATA;
               end
            end
            S_DATA: begin
               if (wait_cnt >= data_end) begin
                  state <= S_PRE;
               end
            end
            S_PRE: begin
               // Close the row once both spacings are met
               if (pre_ok) begin
                  link.cmd <= ddr_pkg::CMD_PRE; // R6 R7
                  link.bank <= op_bank;
                  link.addr <= '0;
                  state <= S_IDLE;
                  req_ready <= 1'b1;
               end
            end
            default: begin
               state <= S_INIT;
               wait_cnt <= 8'h00;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Data path
   // ------------------------------------------------------------
   // Write drive: strobe only for words really present
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         link.ctl_dq_o <= '0;
         link.ctl_dq_oe <= 1'b0;
         link.ctl_dqs_o <= 1'b0;
         link.ctl_dqs_oe <= 1'b0;
      end else begin
         link.ctl_dq_o <= fifo_pop ? fifo_data : '0;
         link.ctl_dq_oe <= send_beat;
         link.ctl_dqs_o <= fifo_pop; // R13
         link.ctl_dqs_oe <= send_beat; // R13
      end
   end

   // Read capture on memory strobe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid <= 1'b0;
         rd_data <= '0;
      end else begin
         rd_valid <= link.dqs && !link.ctl_dqs_oe;
         rd_data <= link.dq;
      end
   end
endmodule

// file: tb/ddr_properties.sv
// Link timing and burst-length checks
`timescale 1ns/1ps
module ddr_properties (
   input wire logic mclk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic [1:0] burst_len_mode, // Burst-length field
   input wire ddr_pkg::cmd_e cmd, // Link command
   input wire logic [ddr_pkg::ADDR_W-1:0] addr, // Link address
   input wire logic ctl_dq_oe, // Controller drives data
   input wire logic dev_dqs_oe // Device drives strobe
);
   wire logic col = (cmd == ddr_pkg::CMD_RD) || (cmd == ddr_pkg::CMD_WR); // Column command
   wire logic rd = cmd == ddr_pkg::CMD_RD; // Read command
   wire logic wr = cmd == ddr_pkg::CMD_WR; // Write command
   wire logic eight = (burst_len_mode == ddr_pkg::BLMODE_FIXED8) ||
                      (burst_len_mode == ddr_pkg::BLMODE_OTF && addr[ddr_pkg::BSEL_POS]); // Eight beats
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_col_spacing: assert property (col |=> !col [*3]) else $error("column spacing");
   a_read_eight: assert property (rd && eight |-> ##6 dev_dqs_oe [*4] ##1 !dev_dqs_oe) else $error("rd8");
   a_read_four: assert property (rd && !eight |-> ##6 dev_dqs_oe [*2] ##1 !dev_dqs_oe) else $error("rd4");
   a_write_eight: assert property (wr && eight |-> ##5 ctl_dq_oe [*4] ##1 !ctl_dq_oe) else $error("wr8");
   a_write_four: assert property (wr && !eight |-> ##5 ctl_dq_oe [*2] ##1 !ctl_dq_oe) else $error("wr4");
   a_pre_read_gap: assert property (rd |=> (cmd != ddr_pkg::CMD_PRE) [*3]) else $error("rtp");
   a_pre_act_gap: assert property (cmd == ddr_pkg::CMD_ACT |=> (cmd != ddr_pkg::CMD_PRE) [*4]) else $error("ras");
   a_act_pre_gap: assert property (cmd == ddr_pkg::CMD_PRE |=> cmd != ddr_pkg::CMD_ACT) else $error("rp");
   a_act_cycle: assert property (cmd == ddr_pkg::CMD_ACT |=> (cmd != ddr_pkg::CMD_ACT) [*6]) else $error("rc");
   c_read_eight: cover property (rd && eight);
   c_read_four: cover property (rd && !eight);
   c_write: cover property (wr);
endmodule

// file: tb/ddr3_burst_read_write_timing_test.sv
// Testbench joining both link ends
`timescale 1ns/1ps
module ddr3_burst_read_write_timing_test;
   logic mclk = 1'b0, rst_n = 1'b0, reinit = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_eight = 1'b0;
   logic wr_valid = 1'b0, req_ready, wr_ready, rd_valid, init_done, write_fault, lbe;
   logic [1:0] mode = 2'h1; // Burst-length field
   logic [2:0] req_bank = 3'h0;
   logic [9:0] req_col = 10'h0;
   logic [31:0] wr_data = 32'h0, rd_data;
   logic [31:0] rq[$]; // Read words seen
   int n_fail = 0, compares = 0, faults = 0;
   ddr_link_if link();
   mem_ctl_end u_mem_ctl_end (.mclk(mclk), .rst_n(rst_n), .link(link.ctl), .burst_len_mode(mode), .reinit(reinit),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank), .req_row(13'h0),
      .req_col(req_col), .req_eight(req_eight), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done));
   dram_end u_dram_end (.mclk(mclk), .rst_n(rst_n), .link(link.dev), .burst_len_mode(mode),
      .write_fault(write_fault), .last_burst_eight(lbe));
   ddr_properties u_ddr_properties (.mclk(mclk), .rst_n(rst_n), .burst_len_mode(mode), .cmd(link.cmd),
      .addr(link.addr), .ctl_dq_oe(link.ctl_dq_oe), .dev_dqs_oe(link.dev_dqs_oe));
   always #4 mclk = ~mclk;
   // Collect read words and fault pulses
   always @(posedge mclk) begin
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (write_fault === 1'b1) faults++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic push(input logic [31:0] d);
      @(negedge mclk);
      wr_valid = 1'b1;
      wr_data = d;
      while (wr_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      wr_valid = 1'b0;
   endtask
   // One request; data zero means no push, reads compared to d+i
   task automatic op(input logic w, input logic e, input logic [2:0] b, input int n, input logic [31:0] d);
      if (w && d != 32'h0) for (int i = 0; i < n; i++) push(d + 32'(i));
      @(negedge mclk);
      req_valid = 1'b1;
      req_write = w;
      req_bank = b;
      req_eight = e;
      while (req_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      req_valid = 1'b0;
      for (int k = 0; k < 60 && req_ready !== 1'b1; k++) @(negedge mclk);
      check({31'h0, req_ready}, 32'h1);
      repeat (10) @(negedge mclk);
      check({31'h0, lbe}, {31'h0, n == 4});
      if (!w) check(32'(rq.size()), 32'(n));
      if (!w) foreach (rq[i]) check(rq[i], d + 32'(i));
      rq.delete();
   endtask
   task automatic final_report;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Main sequence; mode table covers every burst-length field
   initial begin
      static logic [1:0] mt[5] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h3};
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      while (init_done !== 1'b1) @(negedge mclk);
      for (int i = 0; i < 5; i++) begin
         mode = mt[i];
         op(1'b1, i[0] ^ 1'b1, 3'(i), (i[0] ^ (i > 1)) ? 2 : 4, 32'ha0 + 32'(16 * i));
         op(1'b0, i[0] ^ 1'b1, 3'(i), (i[0] ^ (i > 1)) ? 2 : 4, 32'ha0 + 32'(16 * i));
      end
      mode = 2'h1;
      op(1'b1, 1'b1, 3'h5, 4, 32'h0);
      check(32'(faults != 0), 32'h1);
      op(1'b1, 1'b1, 3'h6, 4, 32'he0);
      op(1'b0, 1'b1, 3'h6, 4, 32'he0);
      reinit = 1'b1;
      @(negedge mclk);
      reinit = 1'b0;
      for (int i = 0; i < 32; i++) push(32'h100 + 32'(i));
      @(negedge mclk);
      check({31'h0, wr_ready}, 32'h0);
      for (int i = 0; i < 8; i++) op(1'b1, 1'b1, 3'h7, 4, 32'h0);
      op(1'b0, 1'b1, 3'h7, 4, 32'h11c);
      final_report;
   end
   // Watchdog, far beyond the thousand or so cycles the tests take
   initial begin
      #200000;
      n_fail++;
      final_report;
   end
endmodule
